// ==== rtl/exec_pkg.sv ====
// Constants, opcodes and register map shared by the instruction execute block.
// Operation
// - Watchdog and both flags clear only after both pre-clear steps have run.
// - Invert the addressed byte into memory or accumulator; only zero flag changes.
// - Low nibble above nine or auxiliary carry set gets six added.
// - High nibble plus nibble carry above nine or carry set gets six, sets carry.
// - Subtract one from the byte into memory or accumulator; zero flag only.
// - Add one to the byte into memory or accumulator; zero flag only.
// - Power-down halts, clears watchdog and prescaler, sets power-down, clears timeout.
// - Direct jump loads the program counter from the instruction, no flags.
// - Copies between memory, immediate and accumulator change no flag.
// - OR accumulator with memory or immediate into accumulator or memory; zero only.
// - Subroutine return pops the program counter, two instruction cycles, no flags.
// - Return-with-value pops the program counter and loads the immediate.
// - Interrupt return pops the program counter and sets global interrupt enable.
// - Rotate left with bit 7 into bit 0, memory or accumulator, no flags.
// - Idle instruction only advances the program counter by one.
// - Writing the low program counter byte costs one more instruction cycle.
package exec_pkg;

	// ----------------------------------------------------------------------
	// Clocking and timing
	// ----------------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int CLKS_PER_ICYCLE = 4;
	localparam logic [7:0] PRESCALE_LAST = 8'hFF;

	// ----------------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------------
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_ACC = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_PC = 8'h0C;
	localparam logic [7:0] ADDR_STACK = 8'h10;
	localparam logic [7:0] ADDR_WATCH = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_MEM_BASE = 8'h40;
	localparam logic [7:0] ADDR_MEM_LAST = 8'h7C;
	localparam int MEM_WORDS = 16;
	localparam logic [3:0] PCL_MEM_ADDR = 4'h2;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int INSTR_OP_LSB = 0;
	localparam int INSTR_OPND_LSB = 8;
	localparam int INSTR_JADDR_LSB = 16;
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_AUX = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_WRAP = 3;
	localparam int FLAG_PD = 4;
	localparam int FLAG_TIMEOUT = 5;
	localparam int FLAG_GIE = 6;
	localparam int FLAG_HALTED = 7;
	localparam int STAT_BUSY = 0;
	localparam int STAT_PRE_FIRST = 1;
	localparam int STAT_PRE_SECOND = 2;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [11:0] PC_RESET = 12'h000;
	localparam logic [7:0] WATCH_RESET = 8'h00;

	typedef enum logic [4:0] {
		OP_IDLE = 5'h00, OP_PRE_FIRST = 5'h01, OP_PRE_SECOND = 5'h02,
		OP_INV_M = 5'h03, OP_INV_A = 5'h04, OP_BCD = 5'h05,
		OP_MINUS_M = 5'h06, OP_MINUS_A = 5'h07, OP_PLUS_M = 5'h08,
		OP_PLUS_A = 5'h09, OP_POWERDOWN = 5'h0A, OP_GOTO = 5'h0B,
		OP_COPY_AM = 5'h0C, OP_COPY_AX = 5'h0D, OP_COPY_MA = 5'h0E,
		OP_UNION_AM = 5'h0F, OP_UNION_AX = 5'h10, OP_UNION_MM = 5'h11,
		OP_POP = 5'h12, OP_POP_VAL = 5'h13, OP_IRQ_EXIT = 5'h14,
		OP_ROT_M = 5'h15, OP_ROT_A = 5'h16
	} op_type;

endpackage

// ==== rtl/bcd_adjust_unit.sv ====
// Combinational decimal adjust of the accumulator.
`timescale 1ns/1ps
`default_nettype none
module bcd_adjust_unit
	import exec_pkg::*;
(
	input wire logic [7:0] acc_in,
	input wire logic aux_in,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out
);
	logic [4:0] low_sum;
	logic [4:0] high_sum;
	logic bcd_low_nibble_carry;

	always_comb begin
		low_sum = {1'b0, acc_in[3:0]};
		if (acc_in[3:0] > 4'h9 || aux_in) begin
			low_sum = low_sum + 5'h06;
		end
		bcd_low_nibble_carry = low_sum[4];
		high_sum = {1'b0, acc_in[7:4]} + {4'h0, bcd_low_nibble_carry};
		if (high_sum > 5'h09 || carry_in) begin
			high_sum = high_sum + 5'h06;
			carry_out = 1'b1;
		end else begin
			carry_out = carry_in;
		end
		result = {high_sum[3:0], low_sum[3:0]};
	end
endmodule
`default_nettype wire

// ==== rtl/watchdog_timer.sv ====
// Watchdog counter behind an 8-bit prescaler.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
	import exec_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	output logic [7:0] count,
	output logic overflow
);
	logic [7:0] prescale_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_r <= 8'h00;
			count <= WATCH_RESET;
			overflow <= 1'b0;
		end else if (clear) begin
			prescale_r <= 8'h00;
			count <= WATCH_RESET;
			overflow <= 1'b0;
		end else begin
			overflow <= 1'b0;
			if (prescale_r == PRESCALE_LAST) begin
				prescale_r <= 8'h00;
				count <= count + 8'h01;
				overflow <= (count == 8'hFF);
			end else begin
				prescale_r <= prescale_r + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/exec_core.sv ====
// Instruction execute subset with its Avalon-MM register slave.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module exec_core
	import exec_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	output logic CORE_BUSY,
	output logic CORE_HALTED,
	output logic IRQ_ENABLE
);
	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	logic [7:0] acc_r;
	logic [7:0] mem_r [MEM_WORDS];
	logic [11:0] pc_r;
	logic [11:0] stack_r;
	logic carry_r;
	logic auxiliary_carry_r;
	logic zero_r;
	logic twos_complement_wrap_flag_r;
	logic powerdown_flag_r;
	logic watchdog_timeout_flag_r;
	logic global_irq_enable_r;
	logic halted_r;
	logic watchdog_preclear_first_r;
	logic watchdog_preclear_second_r;
	logic busy_r;
	logic [3:0] cnt_r;
	op_type op_r;
	logic [7:0] opnd_r;
	logic [11:0] jaddr_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [7:0] wd_count;

	// ----------------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------------
	logic req;
	logic stall;
	logic take;
	logic wr;
	logic [31:0] rd_val;
	logic mem_sel;
	logic [3:0] bus_maddr;

	assign req = READ | WRITE;
	// Writes wait while an instruction runs, so bus and execution never
	// update the same state in one cycle.
	assign stall = WRITE & busy_r;
	assign take = req & wait_r & ~stall;
	assign wr = WRITE & ~wait_r;
	assign mem_sel = (ADDRESS >= ADDR_MEM_BASE) && (ADDRESS <= ADDR_MEM_LAST)
		&& (ADDRESS[1:0] == 2'b00);
	assign bus_maddr = ADDRESS[5:2];

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wait_r <= 1'b1;
		end else if (!wait_r) begin
			wait_r <= 1'b1;
		end else if (take) begin
			wait_r <= 1'b0;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (mem_sel) begin
			rd_val = {24'h000000, mem_r[bus_maddr]};
		end else begin
			case (ADDRESS)
				ADDR_ACC: rd_val = {24'h000000, acc_r};
				ADDR_FLAGS: rd_val = {24'h000000, halted_r, global_irq_enable_r,
					watchdog_timeout_flag_r, powerdown_flag_r,
					twos_complement_wrap_flag_r, zero_r, auxiliary_carry_r, carry_r};
				ADDR_PC: rd_val = {20'h00000, pc_r};
				ADDR_STACK: rd_val = {20'h00000, stack_r};
				ADDR_WATCH: rd_val = {24'h000000, wd_count};
				ADDR_STATUS: rd_val = {29'h00000000, watchdog_preclear_second_r,
					watchdog_preclear_first_r, busy_r};
				ADDR_INSTR: rd_val = {4'h0, jaddr_r, opnd_r, 3'b000, op_r};
				default: rd_val = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= 32'h0000_0000;
		end else if (take && READ) begin
			rdata_r <= rd_val;
		end
	end

	// ----------------------------------------------------------------------
	// Instruction issue and cycle count
	// ----------------------------------------------------------------------
	logic issue;
	op_type new_op;
	logic [3:0] new_maddr;
	logic [3:0] new_cnt;
	logic retire;

	function automatic logic writes_mem(input op_type op);
		case (op)
			OP_INV_M, OP_BCD, OP_MINUS_M, OP_PLUS_M,
			OP_COPY_MA, OP_UNION_MM, OP_ROT_M: writes_mem = 1'b1;
			default: writes_mem = 1'b0;
		endcase
	endfunction

	assign new_op = op_type'(WRITEDATA[INSTR_OP_LSB +: 5]);
	assign new_maddr = WRITEDATA[INSTR_OPND_LSB +: 4];
	// An instruction written while halted is dropped.
	assign issue = wr && (ADDRESS == ADDR_INSTR) && !halted_r;
	assign retire = busy_r && (cnt_r == 4'h0);

	always_comb begin
		case (new_op)
			OP_POP, OP_POP_VAL, OP_IRQ_EXIT, OP_GOTO: new_cnt = 4'(2 * CLKS_PER_ICYCLE - 1);
			default: new_cnt = 4'(CLKS_PER_ICYCLE - 1);
		endcase
		// extra instruction cycle on low PC write
		if (writes_mem(new_op) && new_maddr == PCL_MEM_ADDR) begin
			new_cnt = new_cnt + 4'(CLKS_PER_ICYCLE);
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			op_r <= OP_IDLE;
			opnd_r <= 8'h00;
			jaddr_r <= 12'h000;
		end else if (issue) begin
			busy_r <= 1'b1;
			cnt_r <= new_cnt;
			op_r <= new_op;
			opnd_r <= WRITEDATA[INSTR_OPND_LSB +: 8];
			jaddr_r <= WRITEDATA[INSTR_JADDR_LSB +: 12];
		end else if (retire) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end

	// ----------------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------------
	logic [3:0] maddr;
	logic [7:0] mval;
	logic [7:0] res;
	logic to_mem;
	logic to_acc;
	logic upd_zero;
	logic [7:0] bcd_res;
	logic bcd_carry;
	logic pair_done;
	logic wd_clear;
	logic wd_overflow;

	assign maddr = opnd_r[3:0];
	// The low program counter byte is visible as one data memory location.
	assign mval = (maddr == PCL_MEM_ADDR) ? pc_r[7:0] : mem_r[maddr];

	bcd_adjust_unit bcd_adjust_unit_i (
		.acc_in(acc_r),
		.aux_in(auxiliary_carry_r),
		.carry_in(carry_r),
		.result(bcd_res),
		.carry_out(bcd_carry)
	);

	always_comb begin
		res = 8'h00;
		to_mem = 1'b0;
		to_acc = 1'b0;
		upd_zero = 1'b0;
		case (op_r)
			OP_INV_M: begin res = ~mval; to_mem = 1'b1; upd_zero = 1'b1; end
			OP_INV_A: begin res = ~mval; to_acc = 1'b1; upd_zero = 1'b1; end
			OP_BCD: begin res = bcd_res; to_mem = 1'b1; end
			OP_MINUS_M: begin res = mval - 8'h01; to_mem = 1'b1; upd_zero = 1'b1; end
			OP_MINUS_A: begin res = mval - 8'h01; to_acc = 1'b1; upd_zero = 1'b1; end
			OP_PLUS_M: begin res = mval + 8'h01; to_mem = 1'b1; upd_zero = 1'b1; end
			OP_PLUS_A: begin res = mval + 8'h01; to_acc = 1'b1; upd_zero = 1'b1; end
			OP_COPY_AM: begin res = mval; to_acc = 1'b1; end
			OP_COPY_AX: begin res = opnd_r; to_acc = 1'b1; end
			OP_COPY_MA: begin res = acc_r; to_mem = 1'b1; end
			OP_UNION_AM: begin res = acc_r | mval; to_acc = 1'b1; upd_zero = 1'b1; end
			OP_UNION_AX: begin res = acc_r | opnd_r; to_acc = 1'b1; upd_zero = 1'b1; end
			OP_UNION_MM: begin res = acc_r | mval; to_mem = 1'b1; upd_zero = 1'b1; end
			OP_POP_VAL: begin res = opnd_r; to_acc = 1'b1; end
			// rotate left, bit 7 into bit 0
			OP_ROT_M: begin res = {mval[6:0], mval[7]}; to_mem = 1'b1; end
			OP_ROT_A: begin res = {mval[6:0], mval[7]}; to_acc = 1'b1; end
			default: begin res = 8'h00; end
		endcase
	end

	// pair completes only with the other recorded
	assign pair_done = retire && ((op_r == OP_PRE_FIRST && watchdog_preclear_second_r)
		|| (op_r == OP_PRE_SECOND && watchdog_preclear_first_r));
	assign wd_clear = pair_done || (retire && op_r == OP_POWERDOWN);

	watchdog_timer watchdog_timer_i (
		.clk(CLK),
		.rst_n(RST_N),
		.clear(wd_clear),
		.count(wd_count),
		.overflow(wd_overflow)
	);

	// ----------------------------------------------------------------------
	// Accumulator and data memory
	// ----------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			acc_r <= ACC_RESET;
		end else if (wr && ADDRESS == ADDR_ACC) begin
			acc_r <= WRITEDATA[7:0];
		end else if (retire && to_acc) begin
			acc_r <= res;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				mem_r[i] <= 8'h00;
			end
		end else if (wr && mem_sel) begin
			mem_r[bus_maddr] <= WRITEDATA[7:0];
		end else if (retire && to_mem && maddr != PCL_MEM_ADDR) begin
			mem_r[maddr] <= res;
		end
	end

	// ----------------------------------------------------------------------
	// Program counter and stack
	// ----------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pc_r <= PC_RESET;
		end else if (wr && ADDRESS == ADDR_PC) begin
			pc_r <= WRITEDATA[11:0];
		end else if (retire) begin
			if (to_mem && maddr == PCL_MEM_ADDR) begin
				pc_r <= {pc_r[11:8], res};
			end else begin
				case (op_r)
					OP_GOTO: pc_r <= jaddr_r;
					OP_POP, OP_POP_VAL, OP_IRQ_EXIT: pc_r <= stack_r;
					default: pc_r <= pc_r + 12'h001;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			stack_r <= PC_RESET;
		end else if (wr && ADDRESS == ADDR_STACK) begin
			stack_r <= WRITEDATA[11:0];
		end
	end

	// ----------------------------------------------------------------------
	// Pre-clear records
	// ----------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			watchdog_preclear_first_r <= 1'b0;
			watchdog_preclear_second_r <= 1'b0;
		end else if (pair_done) begin
			watchdog_preclear_first_r <= 1'b0;
			watchdog_preclear_second_r <= 1'b0;
		end else if (retire && op_r == OP_PRE_FIRST) begin
			watchdog_preclear_first_r <= 1'b1;
		end else if (retire && op_r == OP_PRE_SECOND) begin
			watchdog_preclear_second_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			carry_r <= 1'b0;
			auxiliary_carry_r <= 1'b0;
			zero_r <= 1'b0;
			twos_complement_wrap_flag_r <= 1'b0;
			powerdown_flag_r <= 1'b0;
			watchdog_timeout_flag_r <= 1'b0;
			global_irq_enable_r <= 1'b0;
			halted_r <= 1'b0;
		end else begin
			if (wr && ADDRESS == ADDR_FLAGS) begin
				carry_r <= WRITEDATA[FLAG_CARRY];
				auxiliary_carry_r <= WRITEDATA[FLAG_AUX];
				zero_r <= WRITEDATA[FLAG_ZERO];
				twos_complement_wrap_flag_r <= WRITEDATA[FLAG_WRAP];
				powerdown_flag_r <= WRITEDATA[FLAG_PD];
				watchdog_timeout_flag_r <= WRITEDATA[FLAG_TIMEOUT];
				global_irq_enable_r <= WRITEDATA[FLAG_GIE];
				halted_r <= halted_r & WRITEDATA[FLAG_HALTED];
			end
			if (retire) begin
				if (upd_zero) begin
					zero_r <= (res == 8'h00);
				end
				if (op_r == OP_BCD) begin
					carry_r <= bcd_carry;
				end
				if (op_r == OP_IRQ_EXIT) begin
					global_irq_enable_r <= 1'b1;
				end
				if (op_r == OP_POWERDOWN) begin
					powerdown_flag_r <= 1'b1;
					watchdog_timeout_flag_r <= 1'b0;
					halted_r <= 1'b1;
				end
				if (pair_done) begin
					powerdown_flag_r <= 1'b0;
					watchdog_timeout_flag_r <= 1'b0;
				end
			end
			// A timeout in the same cycle as a software clear must not be lost.
			if (wd_overflow) begin
				watchdog_timeout_flag_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	assign READDATA = rdata_r;
	assign WAITREQUEST = wait_r;
	assign CORE_BUSY = busy_r;
	assign CORE_HALTED = halted_r;
	assign IRQ_ENABLE = global_irq_enable_r;
endmodule
`default_nettype wire

// ==== sim/exec_core_asserts.sv ====
// Concurrent checks on the ports of the instruction execute block.
`timescale 1ns/1ps
`default_nettype none
module exec_core_asserts
	import exec_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [31:0] READDATA,
	input wire logic WAITREQUEST,
	input wire logic CORE_BUSY,
	input wire logic CORE_HALTED,
	input wire logic IRQ_ENABLE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------------
	logic [3:0] bcnt_r;
	logic fw;
	assign fw = WRITE && !WAITREQUEST && ADDRESS == ADDR_FLAGS;
	// Counts sampled busy cycles, so a finished execution shows its length.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bcnt_r <= 4'h0;
		end else if (CORE_BUSY) begin
			bcnt_r <= bcnt_r + 4'h1;
		end else begin
			bcnt_r <= 4'h0;
		end
	end
	// ----------------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------------
	property p_exec_len;
		$fell(CORE_BUSY) |-> bcnt_r == 4'h4 || bcnt_r == 4'h8 || bcnt_r == 4'hC;
	endproperty
	a_exec_len: assert property (p_exec_len) else $error("execution length wrong");
	property p_start;
		$rose(CORE_BUSY) |-> $past(WRITE && !WAITREQUEST && ADDRESS == ADDR_INSTR && !CORE_HALTED);
	endproperty
	a_start: assert property (p_start) else $error("execution began without a command");
	property p_irq_rise;
		$rose(IRQ_ENABLE) |-> $fell(CORE_BUSY) || $past(fw);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq enable rose unprompted");
	property p_irq_exit_len;
		$rose(IRQ_ENABLE) && $fell(CORE_BUSY) |-> bcnt_r == 4'h8;
	endproperty
	a_irq_exit_len: assert property (p_irq_exit_len) else $error("interrupt return length");
	property p_irq_fall;
		$fell(IRQ_ENABLE) |-> $past(fw && !WRITEDATA[FLAG_GIE]);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq enable fell unprompted");
	property p_halt_rise;
		$rose(CORE_HALTED) |-> $fell(CORE_BUSY) && bcnt_r == 4'h4;
	endproperty
	a_halt_rise: assert property (p_halt_rise) else $error("halt entry timing wrong");
	property p_halt_fall;
		$fell(CORE_HALTED) |-> $past(fw && !WRITEDATA[FLAG_HALTED]);
	endproperty
	a_halt_fall: assert property (p_halt_fall) else $error("halt left unprompted");
	property p_halt_drop;
		CORE_HALTED && WRITE && !WAITREQUEST && ADDRESS == ADDR_INSTR |=> !CORE_BUSY [*4];
	endproperty
	a_halt_drop: assert property (p_halt_drop) else $error("command ran while halted");
endmodule
bind exec_core exec_core_asserts exec_core_asserts_i (.CLK(CLK), .RST_N(RST_N),
	.ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
	.READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .CORE_BUSY(CORE_BUSY),
	.CORE_HALTED(CORE_HALTED), .IRQ_ENABLE(IRQ_ENABLE));
`default_nettype wire

// ==== sim/test_exec_core.sv ====
// Self-checking testbench for the instruction execute block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module test_exec_core
	import exec_pkg::*;
;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] ADDRESS = 8'h00;
	logic READ = 1'b0;
	logic WRITE = 1'b0;
	logic [31:0] WRITEDATA = 32'h0;
	logic [31:0] READDATA;
	logic WAITREQUEST, CORE_BUSY, CORE_HALTED, IRQ_ENABLE;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int busy_n;
	logic [31:0] rd;
	logic [11:0] pc0;
	always #20 CLK = ~CLK;
	exec_core exec_core_i (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ),
		.WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
		.CORE_BUSY(CORE_BUSY), .CORE_HALTED(CORE_HALTED), .IRQ_ENABLE(IRQ_ENABLE));
	// ----------------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------------
	task automatic end_of_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// The request is held until waitrequest is sampled low; a hang ends at the bench timeout.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDRESS <= a;
		WRITE <= wr;
		READ <= !wr;
		WRITEDATA <= d;
		do begin
			@(posedge CLK);
		end while (WAITREQUEST !== 1'b0);
		rd = READDATA;
		WRITE <= 1'b0;
		READ <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic exec(input op_type op, input logic [7:0] opnd, input logic [11:0] ja);
		bus(1'b1, ADDR_INSTR, {4'h0, ja, opnd, 3'h0, op});
		busy_n = 0;
		do begin
			@(posedge CLK);
			busy_n++;
		end while (CORE_BUSY !== 1'b0);
		busy_n--;
	endtask
	function automatic logic [7:0] ma(input logic [3:0] i);
		return ADDR_MEM_BASE + {2'h0, i, 2'h0};
	endfunction
	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic t_reset();
		`CHK(WAITREQUEST, 1'b1)
		rdchk(ADDR_FLAGS, 32'h0);
		rdchk(ADDR_PC, 32'h0);
		bus(1'b1, 8'h30, 32'h5);
		rdchk(8'h30, 32'h0);
	endtask
	task automatic t_ops();
		op_type ops[15] = '{OP_INV_M, OP_INV_A, OP_MINUS_M, OP_MINUS_A, OP_PLUS_M, OP_PLUS_A,
			OP_ROT_M, OP_ROT_A, OP_COPY_AM, OP_COPY_AX, OP_COPY_MA, OP_UNION_AM, OP_UNION_AX,
			OP_UNION_MM, OP_IDLE};
		logic [7:0] av[3] = '{8'h00, 8'h3C, 8'h00};
		logic [7:0] mv[3] = '{8'h01, 8'hFF, 8'h00};
		logic [7:0] a, v, r, fl;
		logic md, za;
		for (int p = 0; p < 3; p++) begin
			for (int k = 0; k < 15; k++) begin
				a = av[p];
				v = mv[p];
				fl = (p == 1) ? 8'h0F : 8'h0B;
				bus(1'b1, ADDR_ACC, {24'h0, a});
				bus(1'b1, ma(4'h5), {24'h0, v});
				bus(1'b1, ADDR_FLAGS, {24'h0, fl});
				bus(1'b0, ADDR_PC, 32'h0);
				pc0 = rd[11:0];
				exec(ops[k], 8'h05, 12'h000);
				md = 1'b0;
				za = 1'b1;
				case (ops[k])
					OP_INV_M, OP_INV_A: r = ~v;
					OP_MINUS_M, OP_MINUS_A: r = v - 8'h01;
					OP_PLUS_M, OP_PLUS_A: r = v + 8'h01;
					OP_UNION_AM, OP_UNION_MM: r = a | v;
					OP_UNION_AX: r = a | 8'h05;
					OP_ROT_M, OP_ROT_A: begin
						r = {v[6:0], v[7]};
						za = 1'b0;
					end
					OP_COPY_AM, OP_COPY_AX: begin
						r = (ops[k] == OP_COPY_AM) ? v : 8'h05;
						za = 1'b0;
					end
					default: begin
						r = a;
						za = 1'b0;
					end
				endcase
				md = ops[k] inside {OP_INV_M, OP_MINUS_M, OP_PLUS_M, OP_ROT_M, OP_COPY_MA, OP_UNION_MM};
				if (za) fl[FLAG_ZERO] = (r == 8'h00);
				rdchk(ADDR_ACC, {24'h0, md ? a : r});
				rdchk(ma(4'h5), {24'h0, md ? r : v});
				rdchk(ADDR_FLAGS, {24'h0, fl});
				rdchk(ADDR_PC, {20'h0, pc0 + 12'h001});
				`CHK(busy_n, 4)
			end
		end
	endtask
	task automatic t_bcd();
		logic [31:0] t[4] = '{32'h9A000001, 32'h15021B02, 32'h4201A201, 32'h38003800};
		foreach (t[i]) begin
			bus(1'b1, ADDR_ACC, {24'h0, t[i][31:24]});
			bus(1'b1, ADDR_FLAGS, {24'h0, t[i][23:16]});
			exec(OP_BCD, 8'h06, 12'h000);
			rdchk(ma(4'h6), {24'h0, t[i][15:8]});
			rdchk(ADDR_FLAGS, {24'h0, t[i][7:0]});
		end
	endtask
	task automatic t_flow();
		bus(1'b1, ADDR_FLAGS, 32'h0F);
		bus(1'b1, ADDR_ACC, 32'h37);
		bus(1'b0, ADDR_PC, 32'h0);
		pc0 = rd[11:0];
		exec(OP_COPY_MA, 8'h02, 12'h000);
		rdchk(ADDR_PC, {20'h0, pc0[11:8], 8'h37});
		`CHK(busy_n, 8)
		exec(OP_GOTO, 8'h00, 12'hABC);
		rdchk(ADDR_PC, 32'hABC);
		bus(1'b1, ADDR_STACK, 32'h456);
		exec(OP_POP, 8'h00, 12'h000);
		rdchk(ADDR_PC, 32'h456);
		`CHK(busy_n, 8)
		bus(1'b1, ADDR_PC, 32'h100);
		exec(OP_POP_VAL, 8'h9E, 12'h000);
		rdchk(ADDR_PC, 32'h456);
		rdchk(ADDR_ACC, 32'h9E);
		`CHK(IRQ_ENABLE, 1'b0)
		bus(1'b1, ADDR_PC, 32'h100);
		exec(OP_IRQ_EXIT, 8'h00, 12'h000);
		`CHK(IRQ_ENABLE, 1'b1)
		rdchk(ADDR_PC, 32'h456);
		rdchk(ADDR_FLAGS, 32'h4F);
	endtask
	task automatic t_watch(input op_type a1, input op_type a2, input logic [31:0] rec);
		repeat (600) @(posedge CLK);
		bus(1'b1, ADDR_FLAGS, 32'h30);
		exec(a1, 8'h00, 12'h000);
		exec(a1, 8'h00, 12'h000);
		rdchk(ADDR_FLAGS, 32'h30);
		rdchk(ADDR_STATUS, rec);
		bus(1'b0, ADDR_WATCH, 32'h0);
		`CHK(rd[7:0] != 8'h00, 1'b1)
		exec(a2, 8'h00, 12'h000);
		rdchk(ADDR_WATCH, 32'h0);
		rdchk(ADDR_FLAGS, 32'h0);
		rdchk(ADDR_STATUS, 32'h0);
	endtask
	task automatic t_halt();
		repeat (600) @(posedge CLK);
		bus(1'b1, ADDR_FLAGS, 32'h20);
		bus(1'b1, ADDR_ACC, 32'h5A);
		bus(1'b0, ADDR_PC, 32'h0);
		pc0 = rd[11:0];
		exec(OP_POWERDOWN, 8'h00, 12'h000);
		`CHK(CORE_HALTED, 1'b1)
		rdchk(ADDR_FLAGS, 32'h90);
		rdchk(ADDR_WATCH, 32'h0);
		rdchk(ADDR_PC, {20'h0, pc0 + 12'h001});
		rdchk(ma(4'h6), 32'h38);
		exec(OP_PLUS_A, 8'h05, 12'h000);
		`CHK(busy_n, 0)
		rdchk(ADDR_ACC, 32'h5A);
		bus(1'b1, ADDR_FLAGS, 32'h0);
		@(posedge CLK);
		`CHK(CORE_HALTED, 1'b0)
	endtask
	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		t_reset();
		t_ops();
		t_bcd();
		t_flow();
		t_watch(OP_PRE_FIRST, OP_PRE_SECOND, 32'h2);
		t_watch(OP_PRE_SECOND, OP_PRE_FIRST, 32'h4);
		t_halt();
		end_of_test();
	end
	// A hang in any wait ends the run here instead of stalling forever.
	always @(posedge CLK) begin
		cycles++;
		if (cycles >= 20000) begin
			failures++;
			end_of_test();
		end
	end
endmodule
`default_nettype wire
